/* core/abpeb_bank.sv */
// Decided for this implementation: the result register offset and the APB interface to the registers.
`include "abpeb_regs.svh"

module abpeb_bank #(
	parameter int TEMP_W = `ABPEB_TEMP_DATA_W
) (
	// System
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Sub-block enables
	output logic                   wavegen_on,
	output logic                   temp_sensor_power,
	output logic                   hs_transimpedance_on,
	output logic                   instr_amp_on,
	output logic                   excitation_buffer_on,
	output logic                   converter_power,
	output logic                   converter_run,
	output logic                   hs_dac_path_on,
	output logic                   hp_reference_powerdown,
	// Temperature conversion handshake
	output logic                   temp_convert_req,
	input  wire logic              temp_convert_done,
	input  wire logic [TEMP_W-1:0] temp_convert_data
);

	////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		abpeb_pkg::abpeb_cfg_type        cfg;
		abpeb_pkg::abpeb_temp_state_type tst;
		logic [TEMP_W-1:0]               temp_result_data;
		logic                            temp_valid;
		logic [31:0]                     rdata;
		logic                            err;
	} abpeb_state_type;

	abpeb_state_type st_r;
	abpeb_state_type st_nxt;

	logic        setup_phase;
	logic        access_phase;
	logic        hit_cfg;
	logic        hit_temp;
	logic        cfg_wr;
	logic [31:0] cfg_rd;
	logic [31:0] temp_rd;
	logic        start_temp;

	////////////////////////////////////////////////////////////////////
	// Address decode
	assign setup_phase  = psel && !penable;
	assign access_phase = psel && penable;
	assign hit_cfg      = (paddr == `ABPEB_CFG_ADDR);
	assign hit_temp     = (paddr == `ABPEB_TEMP_ADDR);
	assign cfg_wr       = access_phase && pwrite && hit_cfg;

	////////////////////////////////////////////////////////////////////
	// Read views
	always_comb begin
		// Bits 31:15 belong elsewhere; they read their reset image
		cfg_rd = `ABPEB_CFG_RST & `ABPEB_CFG_UPPER_MSK; // R15
		cfg_rd[`ABPEB_BIT_WAVEGEN]  = st_r.cfg.wavegen_on;
		cfg_rd[`ABPEB_BIT_TEMPTRIG] = st_r.cfg.temp_measure_trigger;
		cfg_rd[`ABPEB_BIT_TEMPPWR]  = st_r.cfg.temp_sensor_power;
		cfg_rd[`ABPEB_BIT_TIA]      = st_r.cfg.hs_transimpedance_on;
		cfg_rd[`ABPEB_BIT_INAMP]    = st_r.cfg.instr_amp_on;
		cfg_rd[`ABPEB_BIT_EXBUF]    = st_r.cfg.excitation_buffer_on;
		cfg_rd[`ABPEB_BIT_CONVRUN]  = st_r.cfg.converter_run;
		cfg_rd[`ABPEB_BIT_CONVPWR]  = st_r.cfg.converter_power;
		cfg_rd[`ABPEB_BIT_DAC]      = st_r.cfg.hs_dac_path_on;
		cfg_rd[`ABPEB_BIT_REFPD]    = st_r.cfg.hp_reference_powerdown;
		cfg_rd[4:0] = 5'h00; // R16
	end

	always_comb begin
		temp_rd = 32'h0000_0000;
		temp_rd[TEMP_W-1:0] = st_r.temp_result_data; // R3
		temp_rd[`ABPEB_TEMP_VALID_BIT] = st_r.temp_valid;
		temp_rd[`ABPEB_TEMP_BUSY_BIT] =
			(st_r.tst == abpeb_pkg::ABPEB_T_BUSY);
	end

	////////////////////////////////////////////////////////////////////
	// Measurement start
	// A one written to the trigger starts a reading only while the
	// sensor is (or becomes) powered; a write while busy is absorbed.
	assign start_temp = cfg_wr
		&& pwdata[`ABPEB_BIT_TEMPTRIG]
		&& pwdata[`ABPEB_BIT_TEMPPWR]; // R2 R5

	////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_nxt = st_r;

		// Read data is captured in setup so it stands from a flop
		if (setup_phase) begin
			st_nxt.err = !(hit_cfg || hit_temp);
			if (!pwrite && hit_cfg) begin
				st_nxt.rdata = cfg_rd;
			end else if (!pwrite && hit_temp) begin
				st_nxt.rdata = temp_rd;
			end else begin
				st_nxt.rdata = 32'h0000_0000;
			end
		end

		// Writes land at the access edge; outputs follow that edge
		if (cfg_wr) begin // R16
			st_nxt.cfg.wavegen_on =
				pwdata[`ABPEB_BIT_WAVEGEN]; // R1
			st_nxt.cfg.temp_measure_trigger =
				pwdata[`ABPEB_BIT_TEMPTRIG]; // R2
			st_nxt.cfg.temp_sensor_power =
				pwdata[`ABPEB_BIT_TEMPPWR]; // R4
			st_nxt.cfg.hs_transimpedance_on =
				pwdata[`ABPEB_BIT_TIA]; // R6
			st_nxt.cfg.instr_amp_on =
				pwdata[`ABPEB_BIT_INAMP]; // R7
			st_nxt.cfg.excitation_buffer_on =
				pwdata[`ABPEB_BIT_EXBUF]; // R8
			st_nxt.cfg.converter_run =
				pwdata[`ABPEB_BIT_CONVRUN]; // R9
			st_nxt.cfg.converter_power =
				pwdata[`ABPEB_BIT_CONVPWR]; // R10
			st_nxt.cfg.hs_dac_path_on =
				pwdata[`ABPEB_BIT_DAC]; // R12
			st_nxt.cfg.hp_reference_powerdown =
				pwdata[`ABPEB_BIT_REFPD]; // R14
		end

		unique case (st_r.tst)
			abpeb_pkg::ABPEB_T_IDLE: begin
				if (start_temp) begin
					st_nxt.tst = abpeb_pkg::ABPEB_T_BUSY;
					st_nxt.temp_valid = 1'b0;
				end
			end
			abpeb_pkg::ABPEB_T_BUSY: begin
				// Powering the sensor down or dropping the trigger
				// abandons the reading; no stale result is posted
				if (!st_r.cfg.temp_sensor_power
					|| !st_r.cfg.temp_measure_trigger) begin // R5
					st_nxt.tst = abpeb_pkg::ABPEB_T_IDLE;
				end else if (temp_convert_done) begin
					st_nxt.tst = abpeb_pkg::ABPEB_T_DONE;
					st_nxt.temp_result_data =
						temp_convert_data; // R3
					st_nxt.temp_valid = 1'b1; // R3
				end
			end
			abpeb_pkg::ABPEB_T_DONE: begin
				// One cycle to drop the request before a new start
				st_nxt.tst = abpeb_pkg::ABPEB_T_IDLE;
			end
			default: begin
				st_nxt.tst = abpeb_pkg::ABPEB_T_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.cfg              <= '0; // R15
			st_r.tst              <= abpeb_pkg::ABPEB_T_IDLE;
			st_r.temp_result_data <= '0;
			st_r.temp_valid       <= 1'b0;
			st_r.rdata            <= 32'h0000_0000;
			st_r.err              <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	// Zero wait states: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign prdata  = st_r.rdata;
	assign pslverr = access_phase && st_r.err;

	assign wavegen_on           = st_r.cfg.wavegen_on; // R1 R13
	assign temp_sensor_power    = st_r.cfg.temp_sensor_power; // R4
	assign hs_transimpedance_on = st_r.cfg.hs_transimpedance_on; // R6
	assign instr_amp_on         = st_r.cfg.instr_amp_on; // R7
	assign excitation_buffer_on = st_r.cfg.excitation_buffer_on; // R8
	assign converter_power      = st_r.cfg.converter_power; // R10
	// Run alone on an unpowered converter does nothing
	assign converter_run = st_r.cfg.converter_run
		&& st_r.cfg.converter_power; // R9 R11
	// Analog DAC path only; the generator keeps its own enable
	assign hs_dac_path_on = st_r.cfg.hs_dac_path_on; // R12 R13
	assign hp_reference_powerdown =
		st_r.cfg.hp_reference_powerdown; // R14
	assign temp_convert_req = (st_r.tst == abpeb_pkg::ABPEB_T_BUSY);

endmodule : abpeb_bank

/* core/abpeb_regs.svh */
`ifndef ABPEB_REGS_SVH
`define ABPEB_REGS_SVH
// Contract
// R1: Bit 14 enables the waveform generator.
// R2: Writing one to bit 13 starts temperature measurement.
// R3: Finished temperature result lands in result register.
// R4: Bit 12 powers the temperature sensor.
// R5: No measurement without the trigger bit set.
// R6: Bit 11 enables high speed transimpedance amplifier.
// R7: Bit 10 enables the instrumentation amplifier.
// R8: Bit 9 enables the excitation buffer.
// R9: Bit 8 lets a powered converter convert.
// R10: Bit 7 powers the converter.
// R11: Software sets run and power for conversions.
// R12: Bit 6 enables DAC, filter and attenuator.
// R13: DAC enable never turns on waveform generator.
// R14: Bit 5 high powers down the reference.
// R15: Config at 0x2000, resets to 0x00080000.
// R16: Bits 4:0 read zero; enables act next edge.

////////////////////////////////////////////////////////////////////////
// Register map
`define ABPEB_CFG_ADDR      32'h0000_2000
`define ABPEB_TEMP_ADDR     32'h0000_2004
`define ABPEB_CFG_RST       32'h0008_0000
`define ABPEB_CFG_UPPER_MSK 32'hffff_8000

////////////////////////////////////////////////////////////////////////
// Configuration bit positions
`define ABPEB_BIT_WAVEGEN   14
`define ABPEB_BIT_TEMPTRIG  13
`define ABPEB_BIT_TEMPPWR   12
`define ABPEB_BIT_TIA       11
`define ABPEB_BIT_INAMP     10
`define ABPEB_BIT_EXBUF     9
`define ABPEB_BIT_CONVRUN   8
`define ABPEB_BIT_CONVPWR   7
`define ABPEB_BIT_DAC       6
`define ABPEB_BIT_REFPD     5

////////////////////////////////////////////////////////////////////////
// Temperature result register fields
`define ABPEB_TEMP_VALID_BIT 31
`define ABPEB_TEMP_BUSY_BIT  30
`define ABPEB_TEMP_DATA_W    16
`endif

/* core/abpeb_pkg.sv */
package abpeb_pkg;

	// Temperature measurement sequence
	typedef enum logic [2:0] {
		ABPEB_T_IDLE = 3'b001,
		ABPEB_T_BUSY = 3'b010,
		ABPEB_T_DONE = 3'b100
	} abpeb_temp_state_type;

	// Configuration bits 14 down to 5
	typedef struct packed {
		logic wavegen_on;
		logic temp_measure_trigger;
		logic temp_sensor_power;
		logic hs_transimpedance_on;
		logic instr_amp_on;
		logic excitation_buffer_on;
		logic converter_run;
		logic converter_power;
		logic hs_dac_path_on;
		logic hp_reference_powerdown;
	} abpeb_cfg_type;

endpackage : abpeb_pkg

/* testbench/abpeb_bank_props.sv */
module abpeb_bank_props (
	// System
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// Enables
	input wire logic        wavegen_on,
	input wire logic        temp_sensor_power,
	input wire logic        hs_transimpedance_on,
	input wire logic        converter_power,
	input wire logic        converter_run,
	input wire logic        hs_dac_path_on,
	input wire logic        hp_reference_powerdown,
	// Temperature
	input wire logic        temp_convert_req,
	input wire logic        temp_convert_done
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr_cfg;
	logic rd_cfg;
	assign wr_cfg = psel && penable && pwrite && paddr == 32'h0000_2000;
	assign rd_cfg = psel && penable && !pwrite && paddr == 32'h0000_2000;
	// Idle only: busy drives a high request and the done cycle follows one
	sequence s_start;
		wr_cfg && pwdata[13] && pwdata[12] && !temp_convert_req
			&& !$past(temp_convert_req);
	endsequence
	sequence s_done;
		temp_convert_req && temp_convert_done;
	endsequence
	////////////////////////////////////////////////////////////////////////
	a_wavegen_write: assert property (
		wr_cfg |=> wavegen_on == $past(pwdata[14])) else $error("wavegen");
	a_sensor_write: assert property (
		wr_cfg |=> temp_sensor_power == $past(pwdata[12])) else $error("sensor");
	a_tia_write: assert property (
		wr_cfg |=> hs_transimpedance_on == $past(pwdata[11])) else $error("tia");
	a_conv_run: assert property (
		wr_cfg |=> converter_run == ($past(pwdata[8]) && $past(pwdata[7])))
		else $error("converter run");
	a_run_needs_pwr: assert property (
		converter_run |-> converter_power) else $error("run without power");
	a_dac_ref: assert property (
		wr_cfg |=> {hs_dac_path_on, hp_reference_powerdown} == $past(pwdata[6:5]))
		else $error("dac or reference");
	a_temp_start: assert property (
		s_start |=> temp_convert_req) else $error("no start");
	a_no_start: assert property (
		wr_cfg && !pwdata[13] && !temp_convert_req |=> !temp_convert_req)
		else $error("start without trigger");
	a_req_drop: assert property (
		s_done |=> !temp_convert_req) else $error("request held");
	a_rsvd_read: assert property (
		rd_cfg |-> prdata[4:0] == 5'h00 && prdata[31:15] == 17'h00010)
		else $error("reserved bits");
endmodule : abpeb_bank_props

bind abpeb_bank abpeb_bank_props u_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .wavegen_on, .temp_sensor_power,
	.hs_transimpedance_on, .converter_power, .converter_run, .hs_dac_path_on,
	.hp_reference_powerdown, .temp_convert_req, .temp_convert_done);

/* testbench/abpeb_bank_tb_top.sv */
module abpeb_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] CFG = 32'h0000_2000;
	localparam logic [31:0] TMP = 32'h0000_2004;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd, seed = 32'h62b76baf;
	logic        pready, pslverr, done = 0, err;
	logic [15:0] tdata = 0;
	logic [9:0]  en;
	logic [31:0] cs [4] = '{32'h0000_0040, 32'h0000_0080, 32'h0000_0100,
		32'hffff_dfff};
	int          err_count = 0, n_compared = 0;
	always #4 pclk = ~pclk;
	abpeb_bank u_abpeb_bank (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .wavegen_on(en[9]),
		.temp_sensor_power(en[8]), .hs_transimpedance_on(en[7]),
		.instr_amp_on(en[6]), .excitation_buffer_on(en[5]),
		.converter_power(en[4]), .converter_run(en[3]), .hs_dac_path_on(en[2]),
		.hp_reference_powerdown(en[1]), .temp_convert_req(en[0]),
		.temp_convert_done(done), .temp_convert_data(tdata));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	function automatic logic [9:0] exp_en(input logic [31:0] d);
		return {d[14], d[12:9], d[7], d[8] & d[7], d[6:5], 1'b0};
	endfunction : exp_en
	task stop_test;
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			err_count++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	// Trigger bit kept clear so no reading starts here
	task wchk(input logic [31:0] d);
		apb(1, CFG, d);
		@(posedge pclk);
		chk("enables", {22'h0, exp_en(d)}, {22'h0, en});
		apb(0, CFG, 0);
		chk("cfg", (d & 32'h0000_7fe0) | 32'h0008_0000, rd);
	endtask : wchk
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		apb(0, CFG, 0);
		chk("reset cfg", 32'h0008_0000, rd);
		chk("reset en", 32'h0, {22'h0, en});
		apb(0, 32'h0000_3000, 0);
		chk("slverr", 32'h1, {31'h0, err});
		for (int k = 0; k < 24; k++) begin
			seed = xs(seed);
			// Power alone, run alone and both are among the corners
			wchk(k < 4 ? cs[k] : seed & ~32'h2000);
		end
		apb(1, TMP, 32'hffff_ffff);
		apb(1, CFG, 32'h0000_1000);
		repeat (2) @(posedge pclk);
		chk("idle req", 32'h0, {31'h0, en[0]});
		apb(1, CFG, 32'h0000_3000);
		@(posedge pclk);
		chk("req", 32'h1, {31'h0, en[0]});
		seed = xs(seed);
		tdata <= seed[15:0];
		done <= 1;
		@(posedge pclk);
		done <= 0;
		@(posedge pclk);
		chk("req end", 32'h0, {31'h0, en[0]});
		apb(0, TMP, 0);
		chk("result", {16'h8000, seed[15:0]}, rd & 32'hc000_ffff);
		// Dropping the trigger mid-reading must abandon it, no result
		apb(1, CFG, 32'h0000_3000);
		apb(1, CFG, 32'h0000_1000);
		repeat (2) @(posedge pclk);
		chk("abandon req", 32'h0, {31'h0, en[0]});
		apb(0, TMP, 0);
		chk("abandon flags", 32'h0, rd & 32'hc000_0000);
		stop_test();
	end
endmodule : abpeb_bank_tb_top
